// [irq_consts.svh]
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// ----------------------------------------
// register indexes (byte address = 4 x index)
// ----------------------------------------
`define CSR_IDX      8'h25
`define EXT_CFG_IDX  8'h26
`define EI0_PINS_IDX 8'h27
`define EI1_PINS_IDX 8'h28
`define PER_STAT_IDX 8'h29
`define PER_EN_IDX   8'h2a

// ----------------------------------------
// clock_reset_supply_status fields
// ----------------------------------------
`define LV_FLAG_BIT  4
`define FAIL_EN_BIT  2
`define SAFE_OSC_BIT 1
`define WD_FLAG_BIT  0
`define BYTE_ZERO 8'h00
`define PINS_RST  8'h00

// ----------------------------------------
// ext config fields
// ----------------------------------------
`define EI0_SENSE_LSB 0
`define EI1_SENSE_LSB 2

// ----------------------------------------
// vectors, fixed priority order
// ----------------------------------------
`define VEC_TRAP    16'hfffc
`define VEC_EI0     16'hfffa
`define VEC_EI1     16'hfff8
`define VEC_CLKFAIL 16'hfff6
`define VEC_PER0    16'hfff4
`define VEC_PER1    16'hfff2

`endif

// [irq_pkg.sv]
package irq_pkg;
   typedef enum logic [1:0] {
      SENSE_LOW  = 2'h0,
      SENSE_FALL = 2'h1,
      SENSE_RISE = 2'h2,
      SENSE_BOTH = 2'h3
   } sense_t;

   // gray along idle -> pc -> x -> a -> cond -> vector
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_PC   = 3'h1,
      ST_X    = 3'h3,
      ST_A    = 3'h2,
      ST_COND = 3'h6,
      ST_VEC  = 3'h7
   } svc_state_t;

   typedef enum logic [2:0] {
      SRC_TRAP    = 3'h0,
      SRC_EI0     = 3'h1,
      SRC_EI1     = 3'h2,
      SRC_CLKFAIL = 3'h3,
      SRC_PER0 = 3'h4,
      SRC_PER1 = 3'h5
   } src_t;
endpackage

// [ext_irq_detect.sv]
`timescale 1ns/1ps
module ext_irq_detect #(
   parameter int PINS = 8
) (
   // clock and reset
   input  wire logic            clock,
   input  wire logic            resetn,
   // pins, already synchronised
   input  wire logic [PINS-1:0] pins,
   input  wire logic [PINS-1:0] pin_en,
   input  wire irq_pkg::sense_t sense,
   // service handshake
   input  wire logic            ack,
   output logic                 req
);
   import irq_pkg::*;

   logic nand_now;
   logic nand_reg;
   logic edge_reg;
   logic edge_hit;

   if (PINS < 1 || PINS > 8) begin : g_pins_check
      $error("ext_irq_detect: PINS must be 1..8");
   end

   // disabled pins forced high so they drop out of the nand
   assign nand_now = ~&(pins | ~pin_en);

   always_comb begin
      case (sense)
         SENSE_FALL: edge_hit = nand_reg & ~nand_now;
         SENSE_RISE: edge_hit = ~nand_reg & nand_now;
         SENSE_BOTH: edge_hit = nand_reg ^ nand_now;
         default:    edge_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         nand_reg <= 1'b0;
      end else begin
         nand_reg <= nand_now;
      end
   end

   // edge latch; a new edge in the ack cycle is kept
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         edge_reg <= 1'b0;
      end else if (edge_hit) begin
         edge_reg <= 1'b1;
      end else if (ack) begin
         edge_reg <= 1'b0;
      end
   end

   // level mode follows the input, no latch
   // no enabled pin leaves the nand low, which must not read as a level request
   assign req = (sense == SENSE_LOW) ? (~nand_now & (|pin_en)) : edge_reg;
endmodule

// [periph_irq_latch.sv]
`timescale 1ns/1ps
module periph_irq_latch (
   // clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // event and software clears
   input  wire logic flag_set,
   input  wire logic write_zero,
   input  wire logic status_access,
   input  wire logic assoc_access,
   output logic      flag
);
   logic armed_reg;

   // status access while set arms the two-step clear
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         armed_reg <= 1'b0;
      end else if (status_access && flag) begin
         armed_reg <= 1'b1;
      end else if (assoc_access || !flag) begin
         armed_reg <= 1'b0;
      end
   end

   // flag is the latch: stays pending while disabled or masked
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flag <= 1'b0;
      end else if (flag_set) begin
         flag <= 1'b1;
      end else if (write_zero || (armed_reg && assoc_access)) begin
         flag <= 1'b0;
      end
   end
endmodule

// [irq_reset_flags.sv]
`timescale 1ns/1ps
`include "irq_consts.svh"
module irq_reset_flags #(
   parameter int PINS             = 8,
   parameter int N_PERIPH         = 2,
   parameter bit MONITOR_ENABLED  = 1'b1,
   parameter bit DETECTOR_ENABLED = 1'b1,
   parameter bit ACTIVE_HALT      = 1'b0
) (
   // clock and resets
   input  wire logic                  clock,
   input  wire logic                  resetn,
   input  wire logic                  por_n,
   // avalon-mm slave
   input  wire logic [9:0]            address,
   input  wire logic                  read,
   input  wire logic                  write,
   input  wire logic [31:0]           writedata,
   output logic [31:0]                readdata,
   output logic                       waitrequest,
   // reset causes and clock monitor (asynchronous)
   input  wire logic                  lowvolt_cause,
   input  wire logic                  wdg_cause,
   input  wire logic                  safe_osc_sel,
   input  wire logic                  main_osc_ok,
   // external interrupt pins (asynchronous)
   input  wire logic [PINS-1:0]       ei0_pins,
   input  wire logic [PINS-1:0]       ei1_pins,
   // peripherals
   input  wire logic [N_PERIPH-1:0]   periph_flag_set,
   input  wire logic [N_PERIPH-1:0]   periph_assoc_access,
   // core
   input  wire logic                  instr_end,
   input  wire logic                  trap_exec,
   input  wire logic                  return_exec,
   input  wire logic                  mask_clear_exec,
   input  wire logic                  mask_set_exec,
   input  wire logic                  wait_exec,
   input  wire logic                  halt_exec,
   input  wire logic                  wait_mode,
   input  wire logic                  halt_mode,
   output logic                       mask_bit,
   output irq_pkg::svc_state_t        svc_state,
   output logic [15:0]                vector,
   output logic                       wake
);
   import irq_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic                lv_s1, lv_s2, wdg_s1, wdg_s2;
   logic                sel_s1, sel_s2, ok_s1, ok_s2, sel_prev;
   logic [PINS-1:0]     ei0_s1, ei0_s2, ei1_s1, ei1_s2;
   logic                run_reg;
   logic                lv_flag_reg, wd_flag_reg, fail_en_reg, safe_osc_reg;
   logic [3:0]          ext_cfg_reg;
   logic [PINS-1:0]     ei0_en_reg, ei1_en_reg;
   logic [N_PERIPH-1:0] per_en_reg, per_flag;
   logic [7:0]          idx;
   logic                done, done_wr, done_rd;
   logic [7:0]          csr_val, rd_next;
   logic                ei0_req, ei1_req, clkfail_req, ext_req;
   logic [N_PERIPH-1:0] per_req, per_wz, per_stat_acc;
   logic                any_mask_req;
   logic                ack_reg;
   src_t                src_reg, src_next;
   logic [15:0]         vec_next;

   if (N_PERIPH < 1 || N_PERIPH > 2) begin : g_periph_check
      $error("irq_reset_flags: N_PERIPH must be 1..2");
   end
   if (PINS < 1 || PINS > 8) begin : g_pins_check
      $error("irq_reset_flags: PINS must be 1..8");
   end

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   always_ff @(posedge clock or negedge por_n) begin
      if (!por_n) begin
         {lv_s1, lv_s2, wdg_s1, wdg_s2} <= 4'h0;
         {sel_s1, sel_s2, ok_s1, ok_s2} <= 4'h0;
         sel_prev                       <= 1'b0;
         ei0_s1 <= '1;
         ei0_s2 <= '1;
         ei1_s1 <= '1;
         ei1_s2 <= '1;
      end else begin
         lv_s1    <= lowvolt_cause;
         lv_s2    <= lv_s1;
         wdg_s1   <= wdg_cause;
         wdg_s2   <= wdg_s1;
         sel_s1   <= safe_osc_sel;
         sel_s2   <= sel_s1;
         ok_s1    <= main_osc_ok;
         ok_s2    <= ok_s1;
         sel_prev <= sel_s2;
         ei0_s1   <= ei0_pins;
         ei0_s2   <= ei0_s1;
         ei1_s1   <= ei1_pins;
         ei1_s2   <= ei1_s1;
      end
   end

   // low until the first edge after resetn release
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // avalon slave: wait low one cycle, act at that edge
   // ----------------------------------------
   assign idx     = address[9:2];
   assign done    = (read | write) & ~waitrequest;
   assign done_wr = done & write;
   assign done_rd = done & read;

   always_comb begin
      csr_val                = `BYTE_ZERO;
      csr_val[`LV_FLAG_BIT]  = lv_flag_reg;
      csr_val[`FAIL_EN_BIT]  = fail_en_reg;
      csr_val[`SAFE_OSC_BIT] = safe_osc_reg;
      csr_val[`WD_FLAG_BIT]  = wd_flag_reg;
   end

   always_comb begin
      rd_next = `BYTE_ZERO;
      case (idx)
         `CSR_IDX:      rd_next = csr_val;
         `EXT_CFG_IDX:  rd_next = {4'h0, ext_cfg_reg};
         `EI0_PINS_IDX: rd_next[PINS-1:0] = ei0_en_reg;
         `EI1_PINS_IDX: rd_next[PINS-1:0] = ei1_en_reg;
         `PER_STAT_IDX: rd_next[N_PERIPH-1:0] = per_flag;
         `PER_EN_IDX:   rd_next[N_PERIPH-1:0] = per_en_reg;
         default:       rd_next = `BYTE_ZERO;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end else if ((read || write) && waitrequest) begin
         waitrequest <= 1'b0;
         readdata    <= {24'h00_0000, rd_next};
      end else begin
         waitrequest <= 1'b1;
      end
   end

   // ----------------------------------------
   // software control registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         fail_en_reg <= 1'b0;
         ext_cfg_reg <= 4'h0;
         ei0_en_reg  <= '0;
         ei1_en_reg  <= '0;
         per_en_reg  <= '0;
      end else if (done_wr) begin
         case (idx)
            `CSR_IDX:      fail_en_reg <= writedata[`FAIL_EN_BIT];
            `EXT_CFG_IDX:  ext_cfg_reg <= writedata[3:0];
            `EI0_PINS_IDX: ei0_en_reg <= writedata[PINS-1:0];
            `EI1_PINS_IDX: ei1_en_reg <= writedata[PINS-1:0];
            `PER_EN_IDX:   per_en_reg <= writedata[N_PERIPH-1:0];
            default:       fail_en_reg <= fail_en_reg;
         endcase
      end
   end

   // ----------------------------------------
   // reset source flags: lv kept across resetn, wd reloaded at each resetn
   // ----------------------------------------
   // por_n only clears them; the cause is caught while resetn holds run low
   always_ff @(posedge clock or negedge por_n) begin
      if (!por_n) begin
         lv_flag_reg <= 1'b0;
         wd_flag_reg <= 1'b0;
      end else if (!run_reg) begin
         if (lv_s2 && DETECTOR_ENABLED) begin
            lv_flag_reg <= 1'b1;
            wd_flag_reg <= 1'b0;
         end else if (wdg_s2) begin
            wd_flag_reg <= 1'b1;
         end else begin
            wd_flag_reg <= 1'b0;
         end
      end else if (done_wr && idx == `CSR_IDX) begin
         if (!writedata[`LV_FLAG_BIT]) lv_flag_reg <= 1'b0;
         if (!writedata[`WD_FLAG_BIT]) wd_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // safe oscillator flag
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         safe_osc_reg <= 1'b0;
      end else if (!MONITOR_ENABLED) begin
         safe_osc_reg <= 1'b0;
      end else if (sel_s2 && !sel_prev) begin
         safe_osc_reg <= 1'b1;
      end else if (done_rd && idx == `CSR_IDX && ok_s2) begin
         safe_osc_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // sources
   // ----------------------------------------
   ext_irq_detect #(.PINS(PINS)) ei0_det (
      .clock  (clock),
      .resetn (resetn),
      .pins   (ei0_s2),
      .pin_en (ei0_en_reg),
      .sense  (sense_t'(ext_cfg_reg[`EI0_SENSE_LSB +: 2])),
      .ack    (ack_reg && src_reg == SRC_EI0),
      .req    (ei0_req)
   );

   ext_irq_detect #(.PINS(PINS)) ei1_det (
      .clock  (clock),
      .resetn (resetn),
      .pins   (ei1_s2),
      .pin_en (ei1_en_reg),
      .sense  (sense_t'(ext_cfg_reg[`EI1_SENSE_LSB +: 2])),
      .ack    (ack_reg && src_reg == SRC_EI1),
      .req    (ei1_req)
   );

   genvar gi;
   generate
      for (gi = 0; gi < N_PERIPH; gi++) begin : g_per
         assign per_wz[gi] = done_wr && idx == `PER_STAT_IDX && !writedata[gi];
         assign per_stat_acc[gi] = done && idx == `PER_STAT_IDX;
         periph_irq_latch per_latch (
            .clock         (clock),
            .resetn        (resetn),
            .flag_set      (periph_flag_set[gi]),
            .write_zero    (per_wz[gi]),
            .status_access (per_stat_acc[gi]),
            .assoc_access  (periph_assoc_access[gi]),
            .flag          (per_flag[gi])
         );
      end
   endgenerate

   assign per_req      = per_flag & per_en_reg;
   assign clkfail_req  = safe_osc_reg & fail_en_reg & MONITOR_ENABLED;
   assign ext_req      = ei0_req | ei1_req;
   assign any_mask_req = ext_req | clkfail_req | (|per_req);

   // ----------------------------------------
   // fixed priority pick
   // ----------------------------------------
   always_comb begin
      src_next = SRC_TRAP;
      vec_next = `VEC_TRAP;
      if (trap_exec) begin
         src_next = SRC_TRAP;
         vec_next = `VEC_TRAP;
      end else if (ei0_req) begin
         src_next = SRC_EI0;
         vec_next = `VEC_EI0;
      end else if (ei1_req) begin
         src_next = SRC_EI1;
         vec_next = `VEC_EI1;
      end else if (clkfail_req) begin
         src_next = SRC_CLKFAIL;
         vec_next = `VEC_CLKFAIL;
      end else if (per_req[0]) begin
         src_next = SRC_PER0;
         vec_next = `VEC_PER0;
      end else begin
         src_next = SRC_PER1;
         vec_next = `VEC_PER1;
      end
   end

   // ----------------------------------------
   // service sequence
   // ----------------------------------------
   // entry only at an instruction boundary, so the current one completes
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         svc_state <= ST_IDLE;
         src_reg   <= SRC_TRAP;
         vector    <= `VEC_TRAP;
      end else begin
         case (svc_state)
            ST_IDLE: begin
               if (instr_end && (trap_exec || (any_mask_req && !mask_bit))) begin
                  svc_state <= ST_PC;
                  src_reg   <= src_next;
                  vector    <= vec_next;
               end
            end
            ST_PC:   svc_state <= ST_X;
            ST_X:    svc_state <= ST_A;
            ST_A:    svc_state <= ST_COND;
            ST_COND: svc_state <= ST_VEC;
            ST_VEC:  svc_state <= ST_IDLE;
            default: svc_state <= ST_IDLE;
         endcase
      end
   end

   // pulse in the vector state clears edge latches of the chosen source
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (svc_state == ST_COND);
      end
   end

   // ----------------------------------------
   // interrupt mask bit
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mask_bit <= 1'b1;
      end else if (svc_state == ST_COND) begin
         mask_bit <= 1'b1;
      end else if (return_exec || mask_clear_exec || wait_exec || halt_exec) begin
         mask_bit <= 1'b0;
      end else if (mask_set_exec) begin
         mask_bit <= 1'b1;
      end
   end

   // ----------------------------------------
   // wake from low power
   // ----------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wake <= 1'b0;
      end else begin
         wake <= (wait_mode && any_mask_req)
              || (halt_mode && (ext_req || (ACTIVE_HALT && clkfail_req)));
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence entry_s;
      svc_state == ST_PC ##1 svc_state == ST_X ##1 svc_state == ST_A;
   endsequence

   sequence finish_s;
      svc_state == ST_COND ##1 (svc_state == ST_VEC && mask_bit);
   endsequence

   svc_steps_a: assert property (@(posedge clock) disable iff (!resetn)
      $rose(svc_state == ST_PC) |-> entry_s ##1 finish_s ##1 svc_state == ST_IDLE)
      else $error("service sequence out of order");
   mask_gate_a: assert property (@(posedge clock) disable iff (!resetn)
      (svc_state == ST_IDLE && instr_end && !trap_exec && mask_bit) |=> svc_state == ST_IDLE)
      else $error("serviced while masked");
   trap_entry_a: assert property (@(posedge clock) disable iff (!resetn)
      (svc_state == ST_IDLE && instr_end && trap_exec) |=> svc_state == ST_PC ##4 vector == `VEC_TRAP)
      else $error("trap not entered");
   clkfail_vector_a: assert property (@(posedge clock) disable iff (!resetn)
      (svc_state == ST_IDLE && instr_end && !mask_bit && !trap_exec && !ext_req && clkfail_req)
      |=> vector == `VEC_CLKFAIL)
      else $error("wrong clock-fail vector");
   clkfail_gate_a: assert property (@(posedge clock) disable iff (!resetn)
      (svc_state == ST_IDLE && instr_end && !trap_exec && !ext_req && per_req == '0 && !fail_en_reg)
      |=> svc_state == ST_IDLE)
      else $error("clock-fail serviced without enable");
   reserved_zero_a: assert property (@(posedge clock) disable iff (!resetn)
      (!waitrequest && read && idx == `CSR_IDX) |-> readdata[7:5] == 3'h0 && !readdata[3])
      else $error("reserved bits not zero");
   safe_osc_keep_a: assert property (@(posedge clock) disable iff (!resetn)
      (MONITOR_ENABLED && sel_s2 && !sel_prev) |=> safe_osc_reg)
      else $error("safe-osc event lost");
   mask_reset_a: assert property (@(posedge clock) disable iff (!resetn)
      !run_reg |-> mask_bit)
      else $error("mask clear after reset");
   halt_wake_a: assert property (@(posedge clock) disable iff (!resetn)
      (halt_mode && !wait_mode && !ext_req && !ACTIVE_HALT) |=> !wake)
      else $error("halt woken by non-external source");
   wait_wake_a: assert property (@(posedge clock) disable iff (!resetn)
      (wait_mode && any_mask_req) |=> wake)
      else $error("wait not woken");
endmodule

// [core_model.sv]
`timescale 1ns/1ps
module core_model (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                resetn,
   // from the block
   input  wire irq_pkg::svc_state_t svc_state,
   input  wire logic                wake,
   // bench controls
   input  wire logic                wait_mode,
   input  wire logic                trap_req,
   // to the block
   output logic                     instr_end,
   output logic                     trap_exec
);
   import irq_pkg::*;
   // ----------------
   // instruction pacing
   // ----------------
   logic [1:0] cnt_reg;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) cnt_reg <= 2'h0;
      else cnt_reg <= cnt_reg + 2'h1;
   end
   // a sleeping core ends nothing until woken, so wake is really needed
   assign instr_end = (cnt_reg == 2'h3) && (svc_state == ST_IDLE) && (!wait_mode || wake);
   assign trap_exec = instr_end && trap_req;
endmodule

// [tb_interrupt_and_reset_flag_logic.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_interrupt_and_reset_flag_logic;
   import irq_pkg::*;
   // ----------------
   // signals
   // ----------------
   logic clock = 0, resetn = 0, por_n = 0, read = 0, write = 0, lowvolt_cause = 0, wdg_cause = 0;
   logic safe_osc_sel = 0, main_osc_ok = 1, return_exec = 0, mask_clear_exec = 0, mask_set_exec = 0;
   logic wait_exec = 0, halt_exec = 0, wait_mode = 0, halt_mode = 0, trap_req = 0;
   logic [9:0] address = 10'h000;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic [7:0] ei0_pins = 8'hff, ei1_pins = 8'hff;
   logic [1:0] periph_flag_set = 2'h0, periph_assoc_access = 2'h0;
   logic waitrequest, mask_bit, wake, instr_end, trap_exec;
   logic [15:0] vector;
   svc_state_t svc_state;
   int fails = 0, n_checks = 0, cyc = 0, k;
   logic [15:0] vx [3] = '{16'hfffa, 16'hfff4, 16'hfff2};
   localparam logic [9:0] a_st = 10'h094, a_cfg = 10'h098, a_e0 = 10'h09c, a_pf = 10'h0a4, a_pe = 10'h0a8;

   irq_reset_flags uut (.clock(clock), .resetn(resetn), .por_n(por_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .lowvolt_cause(lowvolt_cause), .wdg_cause(wdg_cause), .safe_osc_sel(safe_osc_sel), .main_osc_ok(main_osc_ok),
      .ei0_pins(ei0_pins), .ei1_pins(ei1_pins), .periph_flag_set(periph_flag_set),
      .periph_assoc_access(periph_assoc_access), .instr_end(instr_end), .trap_exec(trap_exec),
      .return_exec(return_exec), .mask_clear_exec(mask_clear_exec), .mask_set_exec(mask_set_exec),
      .wait_exec(wait_exec), .halt_exec(halt_exec), .wait_mode(wait_mode), .halt_mode(halt_mode),
      .mask_bit(mask_bit), .svc_state(svc_state), .vector(vector), .wake(wake));
   core_model core (.clock(clock), .resetn(resetn), .svc_state(svc_state), .wake(wake),
      .wait_mode(wait_mode), .trap_req(trap_req), .instr_end(instr_end), .trap_exec(trap_exec));

   always #5 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc > 3000) begin
         fails++;
         final_report;
      end
   end
   // ----------------
   // tasks
   // ----------------
   task final_report;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // request held until waitrequest is seen low at an edge
   task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge clock);
      read <= ~w;
      write <= w;
      address <= a;
      writedata <= {24'h0, d};
      do @(posedge clock); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task rd(input logic [9:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      `CHK(q, {24'h0, e})
   endtask
   // causes held for four edges, sync needs three
   task rst(input logic l, input logic w);
      @(posedge clock);
      resetn <= 1'b0;
      lowvolt_cause <= l;
      wdg_cause <= w;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      lowvolt_cause <= 1'b0;
      wdg_cause <= 1'b0;
   endtask
   task wst(input svc_state_t s);
      k = 0;
      while (svc_state !== s && k < 60) begin
         @(negedge clock);
         k++;
      end
      `CHK(svc_state, s)
   endtask
   task core_op(input logic [4:0] v);
      @(posedge clock);
      {return_exec, mask_clear_exec, mask_set_exec, wait_exec, halt_exec} <= v;
      @(posedge clock);
      {return_exec, mask_clear_exec, mask_set_exec, wait_exec, halt_exec} <= 5'h00;
   endtask
   task flags(input logic [1:0] v);
      @(posedge clock);
      periph_flag_set <= v;
      @(posedge clock);
      periph_flag_set <= 2'h0;
   endtask
   // ----------------
   // sequence
   // ----------------
   initial begin
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      por_n <= 1'b1;
      @(negedge clock);
      `CHK(mask_bit, 1'b1)
      rd(a_st, 8'h00);
      bus(1'b1, a_st, 8'hff);
      rd(a_st, 8'h04);
      bus(1'b1, 10'h3fc, 8'hff);
      rd(10'h3fc, 8'h00);
      rst(1'b0, 1'b1);
      rd(a_st, 8'h01);
      rst(1'b1, 1'b0);
      rd(a_st, 8'h10);
      rst(1'b0, 1'b1);
      rd(a_st, 8'h11);
      rst(1'b0, 1'b0);
      rd(a_st, 8'h10);
      bus(1'b1, a_st, 8'h00);
      rd(a_st, 8'h00);
      trap_req <= 1'b1;
      wst(ST_PC);
      `CHK(vector, 16'hfffc)
      @(posedge clock) trap_req <= 1'b0;
      wst(ST_IDLE);
      bus(1'b1, a_cfg, 8'h0a);
      bus(1'b1, a_e0, 8'h01);
      bus(1'b1, a_pe, 8'h03);
      bus(1'b1, a_st, 8'h04);
      safe_osc_sel <= 1'b1;
      main_osc_ok <= 1'b0;
      repeat (4) @(posedge clock);
      rd(a_st, 8'h06);
      core_op(5'h08);
      wst(ST_PC);
      `CHK(vector, 16'hfff6)
      wst(ST_IDLE);
      `CHK(mask_bit, 1'b1)
      bus(1'b1, a_st, 8'h00);
      core_op(5'h10);
      repeat (8) @(posedge clock);
      `CHK(mask_bit, 1'b0)
      `CHK(svc_state, ST_IDLE)
      rd(a_st, 8'h02);
      main_osc_ok <= 1'b1;
      safe_osc_sel <= 1'b0;
      repeat (4) @(posedge clock);
      rd(a_st, 8'h02);
      rd(a_st, 8'h00);
      core_op(5'h04);
      halt_mode <= 1'b1;
      flags(2'h3);
      repeat (2) @(posedge clock);
      `CHK(wake, 1'b0)
      ei0_pins <= 8'hfe;
      repeat (5) @(posedge clock);
      `CHK(wake, 1'b1)
      halt_mode <= 1'b0;
      rd(a_pf, 8'h03);
      bus(1'b1, a_pf, 8'h02);
      rd(a_pf, 8'h02);
      flags(2'h1);
      `CHK(svc_state, ST_IDLE)
      wait_mode <= 1'b1;
      core_op(5'h02);
      for (k = 0; k < 10 && wake !== 1'b1; k++) @(negedge clock);
      `CHK(wake, 1'b1)
      @(posedge clock) wait_mode <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         wst(ST_PC);
         `CHK(vector, vx[i])
         wst(ST_IDLE);
         `CHK(mask_bit, 1'b1)
         if (i == 1) bus(1'b1, a_pf, 8'h02);
         if (i == 2) begin
            rd(a_pf, 8'h02);
            @(posedge clock) periph_assoc_access <= 2'h2;
            @(posedge clock) periph_assoc_access <= 2'h0;
         end
         core_op(5'h10);
      end
      bus(1'b1, a_cfg, 8'h08);
      ei0_pins <= 8'hff;
      wst(ST_PC);
      `CHK(vector, 16'hfffa)
      @(posedge clock) ei0_pins <= 8'hfe;
      wst(ST_IDLE);
      core_op(5'h10);
      repeat (10) @(posedge clock);
      `CHK(svc_state, ST_IDLE)
      rd(a_pf, 8'h00);
      final_report;
   end
endmodule
